// [rtl/pxoc_pkg.sv]
// Constants for the proximity output conditioning block
package pxoc_pkg;

  // Timing
  localparam int CLK_PERIOD_NS   = 100;
  localparam int MS_NS           = 1000000;
  localparam int MS_CYCLES_DEF   = (MS_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int MS_PER_HOUR_DEF = 3600000;
  localparam int SPEED_WIN_MS    = 1000;
  localparam int FLASH_HALF_MS   = 500;
  localparam int PPM_PER_WIN     = 60;

  // Register byte offsets
  localparam logic [7:0] A_CFG    = 8'h00;
  localparam logic [7:0] A_ONDLY  = 8'h04;
  localparam logic [7:0] A_OFFDLY = 8'h08;
  localparam logic [7:0] A_STDLY  = 8'h0c;
  localparam logic [7:0] A_TLIM   = 8'h10;
  localparam logic [7:0] A_TEMP   = 8'h14;
  localparam logic [7:0] A_HLIM   = 8'h18;
  localparam logic [7:0] A_CLIM   = 8'h1c;
  localparam logic [7:0] A_HOURS  = 8'h20;
  localparam logic [7:0] A_CYCLES = 8'h24;
  localparam logic [7:0] A_STATUS = 8'h28;
  localparam logic [7:0] A_CMD    = 8'h2c;
  localparam logic [7:0] A_SPLIM  = 8'h30;
  localparam logic [7:0] A_SPEED  = 8'h34;
  localparam logic [2:0] A_MARK_HI = 3'h2;
  localparam int         MARK_WORDS = 8;

  // Configuration word fields
  localparam int CFG_W       = 20;
  localparam int F_FUNC_LSB  = 0;
  localparam int F_HYST      = 2;
  localparam int F_POL1_LSB  = 3;
  localparam int F_POL2_LSB  = 6;
  localparam int F_DIST1_LSB = 9;
  localparam int F_DIST2_LSB = 12;
  localparam int F_LEDM_LSB  = 15;
  localparam int F_LEDT      = 17;
  localparam int F_UNIT_LSB  = 18;
  localparam int NVM_W       = CFG_W + 48;
  localparam int CMD_SAVE    = 0;
  localparam int CMD_CLRUPD  = 1;

  // Encodings
  localparam logic [1:0] FN_ONE = 2'h0, FN_TWO = 2'h1, FN_ANALOG = 2'h2, FN_SPEED = 2'h3;
  localparam logic [2:0] POL_PNP_NO = 3'h0, POL_PNP_NC = 3'h1, POL_NPN_NO = 3'h2;
  localparam logic [2:0] POL_NPN_NC = 3'h3, POL_PP_NO = 3'h4, POL_PP_NC = 3'h5;
  localparam logic [2:0] POL_TEMP = 3'h6, POL_INSP = 3'h7;
  localparam logic [1:0] LED_FULL = 2'h0, LED_OUT = 2'h1;
  localparam logic [1:0] UNIT_C = 2'h0, UNIT_F = 2'h1, UNIT_K = 2'h2;
  localparam logic [2:0] DIST_MAX = 3'h5;

  // Reset values
  localparam logic [CFG_W-1:0] CFG_RST  = 20'h04a00;
  localparam logic [15:0]      DELAY_MAX = 16'hea60;
  localparam logic [15:0]      DLY_RST  = 16'h0000;
  localparam logic [11:0]      TLO_RST  = 12'hfe7;
  localparam logic [11:0]      THI_RST  = 12'h055;
  localparam logic [31:0]      LIM_RST  = 32'hffffffff;
  localparam logic [15:0]      SPMIN_RST = 16'h0000;
  localparam logic [15:0]      SPMAX_RST = 16'h7530;

endpackage

// [rtl/pxoc_top.sv]
// Output conditioning, status packing and register file of the proximity sensor
`timescale 1ns/100ps

module pxoc_top
  import pxoc_pkg::*;
#(
  parameter int MS_CYCLES   = MS_CYCLES_DEF,
  parameter int MS_PER_HOUR = MS_PER_HOUR_DEF
)
(
  input  wire logic                    core_clk_i,         // 10 MHz clock
  input  wire logic                    rst_i,              // Async reset, active high
  input  wire logic                    ce_i,               // Clock enable
  input  wire logic [4:0]              sense_i,            // Actuation at 20..100 % steps, async
  input  wire logic                    standard_io_mode_i, // Standard I/O mode, async
  input  wire logic signed [11:0]      temp_c_i,           // Internal temperature in deg C
  input  wire logic [NVM_W-1:0]        nvm_data_i,         // Stored parameters
  input  wire logic [7:0]              address_i,          // Avalon byte address
  input  wire logic                    read_i,             // Avalon read
  input  wire logic                    write_i,            // Avalon write
  input  wire logic [31:0]             writedata_i,        // Avalon write data
  input  wire logic [3:0]              byteenable_i,       // Avalon byte enables
  output logic [31:0]                  readdata_o,         // Avalon read data
  output logic                         waitrequest_o,      // Avalon waitrequest
  output logic                         out1_hi_o,          // Output 1 high-side drive
  output logic                         out1_lo_o,          // Output 1 low-side drive
  output logic                         out2_hi_o,          // Output 2 high-side drive
  output logic                         out2_lo_o,          // Output 2 low-side drive
  output logic                         led_green_o,        // Green indicator
  output logic                         led_yellow_o,       // Yellow indicator
  output logic [15:0]                  pdata_o,            // Cyclic process data
  output logic                         update_req_o,       // Data update request
  output logic                         nvm_save_o,         // Store strobe
  output logic [NVM_W-1:0]             nvm_data_o          // Parameters to store
);

  function automatic logic [31:0] be_merge(input logic [31:0] old, input logic [31:0] wd,
                                           input logic [3:0] be);
    logic [31:0] m;
    m = {{8{be[3]}}, {8{be[2]}}, {8{be[1]}}, {8{be[0]}}};
    return (old & ~m) | (wd & m);
  endfunction

  // Clamp distances to 1..5 steps and keep output 1 beyond output 2 except in speed mode
  function automatic logic [CFG_W-1:0] fix_cfg(input logic [CFG_W-1:0] c);
    logic [2:0] d1;
    logic [2:0] d2;
    logic [CFG_W-1:0] r;
    d1 = c[F_DIST1_LSB+:3];
    d2 = c[F_DIST2_LSB+:3];
    r  = c;
    if (d1 == 3'h0 || d1 > DIST_MAX) d1 = DIST_MAX;
    if (d2 == 3'h0 || d2 > DIST_MAX) d2 = DIST_MAX;
    if (c[F_FUNC_LSB+:2] != FN_SPEED && d1 <= d2)
    begin
      if (d2 == DIST_MAX) d2 = DIST_MAX - 3'h1;
      d1 = d2 + 3'h1;
    end
    r[F_DIST1_LSB+:3] = d1;
    r[F_DIST2_LSB+:3] = d2;
    return r;
  endfunction

  // Returns {high side, low side}
  function automatic logic [1:0] drv(input logic [2:0] pol, input logic a);
    unique case (pol)
      POL_PNP_NO: return {a, 1'b0};
      POL_PNP_NC: return {~a, 1'b0};
      POL_NPN_NO: return {1'b0, a};
      POL_NPN_NC: return {1'b0, ~a};
      POL_PP_NC:  return {~a, a};
      default:    return {a, ~a};
    endcase
  endfunction

  // Code of the nearest actuated step, zero when not actuated
  function automatic logic [2:0] acode(input logic [4:0] s);
    if (s[0]) return 3'h5;
    if (s[1]) return 3'h4;
    if (s[2]) return 3'h3;
    if (s[3]) return 3'h2;
    if (s[4]) return 3'h1;
    return 3'h0;
  endfunction

  logic [4:0]        s_meta_r, s_sync_r, s_prev_r;
  logic              stdio_meta_r, stdio_r;
  logic              wait_r, load_pend_r;
  logic [CFG_W-1:0]  cfg_r;
  logic [15:0]       on_dly_r, off_dly_r, st_dly_r, sp_min_r, sp_max_r;
  logic [11:0]       tlo_r, thi_r;
  logic [31:0]       hlim_r, clim_r, hours_r, cycles_r, hour_ms_r, ms_pre_r;
  logic [31:0]       mark_r [MARK_WORDS];
  logic              act1_r, ond_q_r, out1_sw_r, st_done_r, flash_r, upd_r, sw1_prev_r;
  logic [15:0]       ond_cnt_r, offd_cnt_r, st_cnt_r, pcnt_r, ppm_r, win_r, flash_cnt_r;
  logic [31:0]       readdata_r;
  logic              o1h_r, o1l_r, o2h_r, o2l_r, ledg_r, ledy_r, save_r;
  logic [15:0]       pd_r;
  logic [NVM_W-1:0]  nvm_r;

  wire         ms_tick    = (ms_pre_r == 32'(MS_CYCLES - 1));
  wire  [1:0]  func       = cfg_r[F_FUNC_LSB+:2];
  wire         one_pt     = (func == FN_ONE);
  wire         two_pt     = (func == FN_TWO);
  wire  [2:0]  pol1       = cfg_r[F_POL1_LSB+:3];
  wire  [2:0]  pol2       = cfg_r[F_POL2_LSB+:3];
  wire  [2:0]  d1         = cfg_r[F_DIST1_LSB+:3];
  wire  [2:0]  d2         = cfg_r[F_DIST2_LSB+:3];
  wire  [1:0]  led_mode   = cfg_r[F_LEDM_LSB+:2];
  wire  [1:0]  unit       = cfg_r[F_UNIT_LSB+:2];
  wire         hyst_small = cfg_r[F_HYST];

  // Standard hysteresis releases one step further out; only in one-point use with d1 below DIST_MAX
  wire  [2:0]  on_idx     = d1 - 3'h1;
  wire  [2:0]  rel_idx    = (hyst_small || !one_pt || d1 == DIST_MAX) ? on_idx : d1;
  wire         act2       = s_sync_r[d2 - 3'h1];
  wire  [15:0] eff_on     = one_pt ? on_dly_r : 16'h0000;
  wire  [15:0] eff_off    = one_pt ? off_dly_r : 16'h0000;

  wire         pulse      = s_sync_r[2] & ~s_prev_r[2];
  wire         sp1        = ppm_r > sp_min_r;
  wire         sp2        = (ppm_r > sp_min_r) && (ppm_r < sp_max_r);
  wire         st_active  = (func == FN_SPEED) && !st_done_r;

  wire signed [11:0] t_lo = tlo_r;
  wire signed [11:0] t_hi = thi_r;
  wire         under      = temp_c_i < t_lo;
  wire         over       = temp_c_i > t_hi;
  wire         talarm     = under | over;
  wire         insp       = (hours_r > hlim_r) || (cycles_r > clim_r);

  wire signed [15:0] t16  = 16'(temp_c_i);
  wire signed [15:0] t_f  = 16'((t16 * 16'sd9) / 16'sd5 + 16'sd32);
  wire signed [15:0] t_k  = t16 + 16'sd273;
  wire signed [15:0] t_rep = (unit == UNIT_F) ? t_f : (unit == UNIT_K) ? t_k : t16;

  wire         sw1        = (func == FN_SPEED) ? (sp1 | st_active)
                          : one_pt ? out1_sw_r : act1_r;
  wire         sw2        = (func == FN_SPEED) ? (sp2 | st_active) : act2;
  wire         temp_ok    = (pol2 == POL_TEMP) && !two_pt && !stdio_r;
  wire         insp_ok    = (pol2 == POL_INSP) && !(two_pt && stdio_r);
  wire         role2      = (pol2 == POL_TEMP) || (pol2 == POL_INSP);
  wire         a2         = temp_ok ? talarm : insp_ok ? insp : sw2;
  wire  [2:0]  pol2_eff   = role2 ? POL_PNP_NO : pol2;
  wire  [1:0]  drv1       = drv(pol1, sw1);
  wire  [1:0]  drv2       = drv(pol2_eff, a2);

  wire  [2:0]  code       = (func == FN_ANALOG && !stdio_r) ? acode(s_sync_r) : 3'h0;
  wire  [7:0]  mark0      = stdio_r ? 8'h00 : mark_r[0][7:0];
  wire  [15:0] pd_nxt     = {mark0, insp, sw2, st_active,
                             (func == FN_ANALOG) ? code : {2'b00, over}, under, sw1};

  wire         green_on   = (led_mode == LED_FULL);
  wire         yellow_on  = (led_mode == LED_FULL) || (led_mode == LED_OUT);
  wire         flash_on   = cfg_r[F_LEDT] && talarm && yellow_on;

  // Bus decode
  wire         wr_en      = write_i & ~wait_r & ce_i;
  wire         wr_cfg     = wr_en && address_i == A_CFG;
  wire         wr_cmd     = wr_en && address_i == A_CMD;
  wire         is_mark    = address_i[7:5] == A_MARK_HI;
  wire  [31:0] wcfg       = be_merge(32'(cfg_r), writedata_i, byteenable_i);
  wire  [CFG_W-1:0] cfg_fixed = fix_cfg(wcfg[CFG_W-1:0]);
  wire  [CFG_W-1:0] nvm_fixed = fix_cfg(nvm_data_i[CFG_W-1:0]);
  wire         cor_wr     = wr_cfg && (cfg_fixed != wcfg[CFG_W-1:0]);
  wire         cor_ld     = load_pend_r && (nvm_fixed != nvm_data_i[CFG_W-1:0]);
  wire         upd_clr    = wr_cmd && byteenable_i[0] && writedata_i[CMD_CLRUPD];
  wire         save_cmd   = wr_cmd && byteenable_i[0] && writedata_i[CMD_SAVE];
  wire  [31:0] rd_mux     =
      (address_i == A_CFG)    ? 32'(cfg_r) :
      (address_i == A_ONDLY)  ? {16'h0000, on_dly_r} :
      (address_i == A_OFFDLY) ? {16'h0000, off_dly_r} :
      (address_i == A_STDLY)  ? {16'h0000, st_dly_r} :
      (address_i == A_TLIM)   ? {4'h0, thi_r, 4'h0, tlo_r} :
      (address_i == A_TEMP)   ? {16'h0000, t_rep} :
      (address_i == A_HLIM)   ? hlim_r :
      (address_i == A_CLIM)   ? clim_r :
      (address_i == A_HOURS)  ? hours_r :
      (address_i == A_CYCLES) ? cycles_r :
      (address_i == A_STATUS) ? {15'h0000, upd_r, pd_r} :
      (address_i == A_SPLIM)  ? {sp_max_r, sp_min_r} :
      (address_i == A_SPEED)  ? {16'h0000, ppm_r} :
      is_mark                 ? mark_r[address_i[4:2]] : 32'h00000000;

  function automatic logic [15:0] dly_clamp(input logic [31:0] v);
    return (v[31:16] != 16'h0000 || v[15:0] > DELAY_MAX) ? DELAY_MAX : v[15:0];
  endfunction

  // Synchronisers and bus handshake
  always_ff @(posedge core_clk_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      s_meta_r   <= 5'h00;
      s_sync_r   <= 5'h00;
      s_prev_r   <= 5'h00;
      stdio_meta_r <= 1'b0;
      stdio_r      <= 1'b0;
      wait_r     <= 1'b1;
      readdata_r <= 32'h00000000;
    end
    else if (ce_i)
    begin
      s_meta_r   <= sense_i;
      s_sync_r   <= s_meta_r;
      s_prev_r   <= s_sync_r;
      stdio_meta_r <= standard_io_mode_i;
      stdio_r      <= stdio_meta_r;
      wait_r     <= wait_r ? ~(read_i | write_i) : 1'b1;
      if (read_i && wait_r)
        readdata_r <= stdio_r ? 32'h00000000 : rd_mux;
    end
  end

  // Parameter registers; configuration and delays loaded from the store once after reset
  always_ff @(posedge core_clk_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      load_pend_r <= 1'b1;
      cfg_r       <= CFG_RST;
      on_dly_r    <= DLY_RST;
      off_dly_r   <= DLY_RST;
      st_dly_r    <= DLY_RST;
      tlo_r       <= TLO_RST;
      thi_r       <= THI_RST;
      hlim_r      <= LIM_RST;
      clim_r      <= LIM_RST;
      sp_min_r    <= SPMIN_RST;
      sp_max_r    <= SPMAX_RST;
      upd_r       <= 1'b0;
      save_r      <= 1'b0;
      nvm_r       <= '0;
    end
    else if (ce_i)
    begin
      load_pend_r <= 1'b0;
      upd_r       <= cor_wr | cor_ld | (upd_r & ~upd_clr);
      save_r      <= save_cmd;
      if (save_cmd)
        nvm_r <= {st_dly_r, off_dly_r, on_dly_r, cfg_r};
      if (load_pend_r)
      begin
        cfg_r     <= nvm_fixed;
        on_dly_r  <= dly_clamp(32'(nvm_data_i[CFG_W+:16]));
        off_dly_r <= dly_clamp(32'(nvm_data_i[CFG_W+16+:16]));
        st_dly_r  <= dly_clamp(32'(nvm_data_i[CFG_W+32+:16]));
      end
      else if (wr_en)
      begin
        if (wr_cfg) cfg_r <= cfg_fixed;
        if (address_i == A_ONDLY)  on_dly_r  <= dly_clamp(be_merge(32'(on_dly_r), writedata_i, byteenable_i));
        if (address_i == A_OFFDLY) off_dly_r <= dly_clamp(be_merge(32'(off_dly_r), writedata_i, byteenable_i));
        if (address_i == A_STDLY)  st_dly_r  <= dly_clamp(be_merge(32'(st_dly_r), writedata_i, byteenable_i));
        if (address_i == A_TLIM)
        begin
          if (byteenable_i[0]) tlo_r[7:0]  <= writedata_i[7:0];
          if (byteenable_i[1]) tlo_r[11:8] <= writedata_i[11:8];
          if (byteenable_i[2]) thi_r[7:0]  <= writedata_i[23:16];
          if (byteenable_i[3]) thi_r[11:8] <= writedata_i[27:24];
        end
        if (address_i == A_HLIM) hlim_r <= be_merge(hlim_r, writedata_i, byteenable_i);
        if (address_i == A_CLIM) clim_r <= be_merge(clim_r, writedata_i, byteenable_i);
        if (address_i == A_SPLIM)
          {sp_max_r, sp_min_r} <= be_merge({sp_max_r, sp_min_r}, writedata_i, byteenable_i);
      end
    end
  end

  // Marking memory, one word per entry
  genvar gi;
  generate
    for (gi = 0; gi < MARK_WORDS; gi++)
    begin : g_mark
      always_ff @(posedge core_clk_i or posedge rst_i)
      begin
        if (rst_i)
          mark_r[gi] <= 32'h00000000;
        else if (wr_en && is_mark && address_i[4:2] == 3'(gi))
          mark_r[gi] <= be_merge(mark_r[gi], writedata_i, byteenable_i);
      end
    end
  endgenerate

  // Millisecond tick, hour and cycle counters
  always_ff @(posedge core_clk_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      ms_pre_r   <= 32'h00000000;
      hour_ms_r  <= 32'h00000000;
      hours_r    <= 32'h00000000;
      cycles_r   <= 32'h00000000;
      sw1_prev_r <= 1'b0;
    end
    else if (ce_i)
    begin
      ms_pre_r   <= ms_tick ? 32'h00000000 : ms_pre_r + 32'h1;
      sw1_prev_r <= sw1;
      if (sw1 && !sw1_prev_r)
        cycles_r <= cycles_r + 32'h1;
      if (ms_tick)
      begin
        if (hour_ms_r == 32'(MS_PER_HOUR - 1))
        begin
          hour_ms_r <= 32'h00000000;
          hours_r   <= hours_r + 32'h1;
        end
        else
          hour_ms_r <= hour_ms_r + 32'h1;
      end
    end
  end

  // Switching with hysteresis, on/off delays, start delay and speed window
  always_ff @(posedge core_clk_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      act1_r      <= 1'b0;
      ond_q_r     <= 1'b0;
      ond_cnt_r   <= 16'h0000;
      out1_sw_r   <= 1'b0;
      offd_cnt_r  <= 16'h0000;
      st_done_r   <= 1'b0;
      st_cnt_r    <= 16'h0000;
      pcnt_r      <= 16'h0000;
      ppm_r       <= 16'h0000;
      win_r       <= 16'h0000;
      flash_r     <= 1'b0;
      flash_cnt_r <= 16'h0000;
    end
    else if (ce_i)
    begin
      if (!act1_r && s_sync_r[on_idx])
        act1_r <= 1'b1;
      else if (act1_r && !s_sync_r[rel_idx])
        act1_r <= 1'b0;
      if (!act1_r)
      begin
        ond_q_r   <= 1'b0;
        ond_cnt_r <= 16'h0000;
      end
      else if (!ond_q_r)
      begin
        if (ond_cnt_r >= eff_on)
          ond_q_r <= 1'b1;
        else if (ms_tick)
          ond_cnt_r <= ond_cnt_r + 16'h1;
      end
      if (ond_q_r)
      begin
        out1_sw_r  <= 1'b1;
        offd_cnt_r <= 16'h0000;
      end
      else if (out1_sw_r)
      begin
        if (offd_cnt_r >= eff_off)
          out1_sw_r <= 1'b0;
        else if (ms_tick)
          offd_cnt_r <= offd_cnt_r + 16'h1;
      end
      // Start delay is judged only once the stored value has been loaded
      if (!st_done_r && !load_pend_r)
      begin
        if (st_cnt_r >= st_dly_r)
          st_done_r <= 1'b1;
        else if (ms_tick)
          st_cnt_r <= st_cnt_r + 16'h1;
      end
      if (ms_tick && win_r == 16'(SPEED_WIN_MS - 1))
      begin
        win_r  <= 16'h0000;
        ppm_r  <= 16'(pcnt_r * 16'(PPM_PER_WIN));
        pcnt_r <= pulse ? 16'h0001 : 16'h0000;
      end
      else
      begin
        if (ms_tick) win_r <= win_r + 16'h1;
        if (pulse) pcnt_r <= pcnt_r + 16'h1;
      end
      if (ms_tick)
      begin
        if (flash_cnt_r == 16'(FLASH_HALF_MS - 1))
        begin
          flash_cnt_r <= 16'h0000;
          flash_r     <= ~flash_r;
        end
        else
          flash_cnt_r <= flash_cnt_r + 16'h1;
      end
    end
  end

  // Registered pin and process data outputs
  always_ff @(posedge core_clk_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      o1h_r  <= 1'b0;
      o1l_r  <= 1'b0;
      o2h_r  <= 1'b0;
      o2l_r  <= 1'b0;
      ledg_r <= 1'b0;
      ledy_r <= 1'b0;
      pd_r   <= 16'h0000;
    end
    else if (ce_i)
    begin
      {o1h_r, o1l_r} <= drv1;
      {o2h_r, o2l_r} <= drv2;
      ledg_r <= flash_on ? flash_r : green_on;
      ledy_r <= yellow_on & sw1;
      pd_r   <= pd_nxt;
    end
  end

  assign readdata_o    = readdata_r;
  assign waitrequest_o = wait_r;
  assign out1_hi_o     = o1h_r;
  assign out1_lo_o     = o1l_r;
  assign out2_hi_o     = o2h_r;
  assign out2_lo_o     = o2l_r;
  assign led_green_o   = ledg_r;
  assign led_yellow_o  = ledy_r;
  assign pdata_o       = pd_r;
  assign update_req_o  = upd_r;
  assign nvm_save_o    = save_r;
  assign nvm_data_o    = nvm_r;

endmodule // pxoc_top

// [bench/pxoc_plc_input.sv]
// Controller digital input model fed by one switching output
`timescale 1ns/100ps
module pxoc_plc_input (
  input  wire logic hi_i,   // High-side drive
  input  wire logic lo_i,   // Low-side drive
  output logic      level_o // Level seen, pulled down when floating
);
  assign level_o = hi_i ? 1'b1 : (lo_i ? 1'b0 : 1'b0);
endmodule // pxoc_plc_input

// [bench/pxoc_checker.sv]
// Bus, output and status checks for the conditioning block
`timescale 1ns/100ps
module pxoc_checker
  import pxoc_pkg::*;
(
  input wire logic core_clk_i, rst_i, ce_i, read_i, write_i, standard_io_mode_i, waitrequest_o,
  input wire logic out1_hi_o, out1_lo_o, out2_hi_o, out2_lo_o, nvm_save_o, update_req_o,
  input wire logic [7:0]  address_i,
  input wire logic [31:0] readdata_o,
  input wire logic [15:0] pdata_o
);
  default clocking @(posedge core_clk_i); endclocking
  default disable iff (rst_i);
  wait_one_a: assert property ((read_i || write_i) && waitrequest_o && ce_i |=> !waitrequest_o)
    else $error("no answer");
  wait_end_a: assert property (!waitrequest_o |=> waitrequest_o)
    else $error("wait too short");
  rd_hold_a: assert property (!read_i |=> $stable(readdata_o))
    else $error("read data moved");
  stdio_read_a: assert property (standard_io_mode_i [*6] ##0 (read_i && !waitrequest_o)
    |-> readdata_o == 32'h00000000) else $error("read data in standard io mode");
  stdio_mark_a: assert property (standard_io_mode_i [*6] |-> pdata_o[15:8] == 8'h00)
    else $error("marking byte in standard io mode");
  out1_drv_a: assert property (!(out1_hi_o && out1_lo_o))
    else $error("out1 shorted");
  out2_drv_a: assert property (!(out2_hi_o && out2_lo_o))
    else $error("out2 shorted");
  upd_hold_a: assert property (update_req_o && !(write_i && address_i == A_CMD) |=> update_req_o)
    else $error("update lost");
  save_one_a: assert property (nvm_save_o |=> !nvm_save_o)
    else $error("save too long");
  rd_done_c: cover property (read_i && !waitrequest_o);
  upd_set_c: cover property ($rose(update_req_o));
  save_c: cover property (nvm_save_o);
  start_end_c: cover property ($fell(pdata_o[5]));
endmodule // pxoc_checker
bind pxoc_top pxoc_checker chk_u (.*);

// [bench/proximity_output_conditioning_test.sv]
// Self-checking bench for the proximity output conditioning block
`timescale 1ns/100ps
module proximity_output_conditioning_test
  import pxoc_pkg::*;
;
  logic               core_clk_i  = 1'b0;
  logic               rst_i       = 1'b1;
  logic               ce_i        = 1'b1;
  logic               read_i      = 1'b0;
  logic               write_i     = 1'b0;
  logic               stdio       = 1'b0;
  logic [4:0]         sense_i     = 5'h00;
  logic signed [11:0] temp_c_i    = 12'sh019;
  logic [7:0]         address_i   = 8'h00;
  logic [31:0]        writedata_i = 32'h00000000;
  logic [NVM_W-1:0]   nvm_in      = {48'h0, CFG_RST};
  logic [31:0]        readdata_o, q;
  logic [NVM_W-1:0]   nvm_q;
  logic [15:0]        pdata_o;
  logic               waitrequest_o, o1h, o1l, o2h, o2l, ledg, ledy, upd, save, in1, in2;
  int                 fail_count  = 0;
  int                 checks_done = 0;
  int                 cycles      = 0;
  int                 saves       = 0;
  pxoc_top #(.MS_CYCLES(10), .MS_PER_HOUR(5)) dut_u (
    .core_clk_i(core_clk_i), .rst_i(rst_i), .ce_i(ce_i), .sense_i(sense_i), .standard_io_mode_i(stdio),
    .temp_c_i(temp_c_i), .nvm_data_i(nvm_in), .address_i(address_i), .read_i(read_i), .write_i(write_i),
    .writedata_i(writedata_i), .byteenable_i(4'hf), .readdata_o(readdata_o), .waitrequest_o(waitrequest_o),
    .out1_hi_o(o1h), .out1_lo_o(o1l), .out2_hi_o(o2h), .out2_lo_o(o2l), .led_green_o(ledg),
    .led_yellow_o(ledy), .pdata_o(pdata_o), .update_req_o(upd), .nvm_save_o(save), .nvm_data_o(nvm_q));
  pxoc_plc_input plc_u (.hi_i(o1h), .lo_i(o1l), .level_o(in1));
  pxoc_plc_input plc2_u (.hi_i(o2h), .lo_i(o2l), .level_o(in2));
  always #50 core_clk_i = ~core_clk_i;
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks_done++;
    if (got !== exp)
    begin
      fail_count++;
      $display("mismatch t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] d);
    address_i <= a;
    writedata_i <= d;
    write_i <= wr;
    read_i <= !wr;
    do @(posedge core_clk_i); while (waitrequest_o !== 1'b0);
    q = readdata_o;
    write_i <= 1'b0;
    read_i <= 1'b0;
    @(posedge core_clk_i);
  endtask
  task automatic t_fix();
    bus(1'b0, A_CFG, 32'h00000000);
    chk(q, {12'h000, CFG_RST});
    bus(1'b1, A_CFG, 32'h00003200);
    bus(1'b0, A_CFG, 32'h00000000);
    chk(q, 32'h00003800);
    chk(upd, 1'b1);
    bus(1'b1, A_CMD, 32'h00000002);
    chk(upd, 1'b0);
  endtask
  task automatic t_temp();
    temp_c_i <= 12'sh064;
    repeat (4) @(posedge core_clk_i);
    chk(pdata_o[2:1], 2'b10);
    temp_c_i <= -12'sh028;
    repeat (4) @(posedge core_clk_i);
    chk(pdata_o[2:1], 2'b01);
    ce_i     <= 1'b0;
    temp_c_i <= 12'sh019;
    repeat (4) @(posedge core_clk_i);
    chk(pdata_o[2:1], 2'b01);
    ce_i <= 1'b1;
    repeat (4) @(posedge core_clk_i);
    chk(pdata_o[2:1], 2'b00);
    bus(1'b1, A_CFG, 32'h00083800);
    bus(1'b0, A_TEMP, 32'h00000000);
    chk(q, 32'h0000012a);
    bus(1'b1, A_CFG, 32'h00003800);
  endtask
  task automatic t_mark();
    bus(1'b1, 8'h40, 32'h0000005a);
    repeat (3) @(posedge core_clk_i);
    chk(pdata_o[15:8], 8'h5a);
    bus(1'b0, 8'h40, 32'h00000000);
    chk(q, 32'h0000005a);
    stdio <= 1'b1;
    repeat (8) @(posedge core_clk_i);
    chk(pdata_o[15:8], 8'h00);
    bus(1'b0, 8'h40, 32'h00000000);
    chk(q, 32'h00000000);
    stdio <= 1'b0;
    repeat (8) @(posedge core_clk_i);
  endtask
  task automatic t_delay();
    logic seen;
    seen = 1'b0;
    bus(1'b1, A_ONDLY, 32'h00000003);
    sense_i <= 5'h1f;
    repeat (12) @(posedge core_clk_i);
    sense_i <= 5'h00;
    repeat (40)
    begin
      @(posedge core_clk_i);
      seen |= pdata_o[0];
    end
    chk(seen, 1'b0);
    sense_i <= 5'h1f;
    repeat (60) @(posedge core_clk_i);
    chk(pdata_o[0], 1'b1);
    chk(in1, 1'b1);
    chk(in2, 1'b1);
    chk({ledg, ledy}, 2'b11);
    bus(1'b1, A_OFFDLY, 32'h00000002);
    sense_i <= 5'h00;
    repeat (8) @(posedge core_clk_i);
    chk(pdata_o[0], 1'b1);
    repeat (32) @(posedge core_clk_i);
    chk(pdata_o[0], 1'b0);
    bus(1'b1, A_CMD, 32'h00000001);
    @(posedge core_clk_i);
    chk(saves, 1);
    chk(nvm_q[31:0], 32'h00303800);
    chk(nvm_q[63:32], 32'h00000020);
    bus(1'b1, A_HLIM, 32'h00000000);
    repeat (2) @(posedge core_clk_i);
    chk(pdata_o[7], 1'b1);
  endtask
  task automatic t_start();
    nvm_in <= {16'h0005, 32'h00000000, CFG_RST | 20'h00003};
    rst_i  <= 1'b1;
    repeat (2) @(posedge core_clk_i);
    rst_i <= 1'b0;
    repeat (4) @(posedge core_clk_i);
    chk(pdata_o[5], 1'b1);
    chk({in1, in2}, 2'b11);
    repeat (60) @(posedge core_clk_i);
    chk(pdata_o[5], 1'b0);
    chk({in1, in2}, 2'b00);
  endtask
  task automatic summarize();
    $display("checks %0d mismatches %0d", checks_done, fail_count);
    if (fail_count == 0 && checks_done > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask
  always @(posedge core_clk_i)
  begin
    cycles++;
    if (save === 1'b1)
      saves++;
    if (cycles == 5000)
    begin
      fail_count++;
      summarize();
    end
  end
  initial
  begin
    repeat (2) @(posedge core_clk_i);
    rst_i <= 1'b0;
    repeat (2) @(posedge core_clk_i);
    t_fix();
    t_temp();
    t_mark();
    t_delay();
    t_start();
    summarize();
  end
endmodule // proximity_output_conditioning_test
